// ### hdl/nbrt_device.sv
// Device end: decodes read cycles and returns one byte from the flash core
`timescale 1ns/1ps
module nbrt_device
    import nbrt_pkg::*;
#(
    parameter int WAIT_CLOCKS = NBRT_WAIT_CLOCKS
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    nbrt_if.device                      bus,
    input  wire logic [3:0]             strap_identifier,
    input  wire logic [7:0]             read_data,
    output logic      [NBRT_ADDR_W-1:0] read_address,
    output logic                        core_select,
    output logic                        read_strobe
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [3:0] bus_meta;
    logic [3:0] bus_sync;
    logic       frame_meta;
    logic       frame_n;
    logic [3:0] strap_meta;
    logic [3:0] strap_sync;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_meta   <= 4'hF;
            bus_sync   <= 4'hF;
            frame_meta <= 1'b1;
            frame_n    <= 1'b1;
            strap_meta <= 4'h0;
            strap_sync <= 4'h0;
        end else begin
            bus_meta   <= bus.nibble_bus;
            bus_sync   <= bus_meta;
            frame_meta <= bus.frame_control_input_n;
            frame_n    <= frame_meta;
            strap_meta <= strap_identifier;
            strap_sync <= strap_meta;
        end
    end

    // ------------------------------------------------------------
    // Protocol state
    // ------------------------------------------------------------
    nbrt_state_t state;
    logic [2:0]  cnt;
    logic [7:0]  data;

    // The link runs two clocks behind the pins; the host model is written
    // for the same lag, so field positions stay aligned end to end.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= NBRT_IDLE;
            cnt   <= NBRT_CNT_ZERO;
        end else if (!frame_n) begin
            // Keep latching start codes; the last one wins
            state <= (bus_sync == NBRT_START_READ) ? NBRT_SEL : NBRT_IDLE;
            cnt   <= NBRT_CNT_ZERO;
        end else begin
            case (state)
                NBRT_IDLE: state <= NBRT_IDLE;
                NBRT_SEL: begin
                    state <= (bus_sync == strap_sync) ? NBRT_ADDR : NBRT_IDLE;
                    cnt   <= NBRT_CNT_ZERO;
                end
                NBRT_ADDR: begin
                    cnt <= cnt + NBRT_CNT_ONE;
                    if (cnt == 3'(NBRT_ADDR_NIBS - 1)) begin
                        state <= NBRT_SIZE;
                    end
                end
                NBRT_SIZE: state <= (bus_sync == NBRT_SIZE_ONE) ? NBRT_TURNAROUND_FIRST : NBRT_IDLE;
                NBRT_TURNAROUND_FIRST: state <= NBRT_TURNAROUND_SECOND;
                NBRT_TURNAROUND_SECOND: begin
                    state <= NBRT_SYNC;
                    cnt   <= NBRT_CNT_ZERO;
                end
                NBRT_SYNC: begin
                    cnt <= cnt + NBRT_CNT_ONE;
                    if (cnt == 3'(WAIT_CLOCKS)) begin
                        state <= NBRT_DATA;
                        cnt   <= NBRT_CNT_ZERO;
                    end
                end
                NBRT_DATA: begin
                    cnt <= cnt + NBRT_CNT_ONE;
                    if (cnt == NBRT_CNT_ONE) begin
                        state <= NBRT_DTAR;
                    end
                end
                NBRT_DTAR: state <= NBRT_IDLE;
                default:   state <= NBRT_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address assembly and core access
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            read_address <= '0;
        end else if (frame_n && state == NBRT_ADDR) begin
            read_address <= {read_address[NBRT_ADDR_W-5:0], bus_sync};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            core_select <= 1'b0;
            read_strobe <= 1'b0;
            data        <= 8'h00;
        end else begin
            core_select <= read_address[NBRT_CORE_SEL];
            read_strobe <= frame_n && state == NBRT_TURNAROUND_FIRST;
            if (frame_n && state == NBRT_SYNC) begin
                data <= read_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus.dev_out <= NBRT_TURN;
            bus.dev_oe  <= 4'h0;
        end else if (!frame_n) begin
            bus.dev_out <= NBRT_TURN;
            bus.dev_oe  <= 4'h0;
        end else begin
            bus.dev_oe <= 4'h0;
            case (state)
                NBRT_TURNAROUND_SECOND: begin
                    bus.dev_out <= NBRT_WAIT_SYNC;
                    bus.dev_oe  <= 4'hF;
                end
                NBRT_SYNC: begin
                    bus.dev_out <= (cnt == 3'(WAIT_CLOCKS)) ? data[3:0]
                                 : (cnt == 3'(WAIT_CLOCKS - 1)) ? NBRT_READY_SYNC
                                 : NBRT_WAIT_SYNC;
                    if (cnt == 3'(WAIT_CLOCKS)) begin
                        bus.dev_out <= read_data[3:0];
                    end
                    bus.dev_oe <= 4'hF;
                end
                NBRT_DATA: begin
                    bus.dev_out <= (cnt == NBRT_CNT_ZERO) ? data[7:4] : NBRT_TURN;
                    bus.dev_oe  <= 4'hF;
                end
                default: bus.dev_out <= NBRT_TURN;
            endcase
        end
    end

endmodule

// ### hdl/nbrt_host.sv
// Host end: issues single-byte read cycles on the nibble bus
`timescale 1ns/1ps
module nbrt_host
    import nbrt_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   rst,
    nbrt_if.host                        bus,
    input  wire logic                   req,
    input  wire logic [3:0]             req_select,
    input  wire logic [3:0]             req_size,
    input  wire logic [NBRT_ADDR_W-1:0] req_address,
    output logic                        busy,
    output logic                        done,
    output logic      [7:0]             rdata
);

    nbrt_state_t state;
    logic [4:0]  cnt;
    logic [NBRT_ADDR_W-1:0] addr;
    logic [3:0]  sel;
    logic [3:0]  size;
    logic [3:0]  in_meta;
    logic [3:0]  in_sync;
    logic        got_ready;

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            in_meta <= 4'hF;
            in_sync <= 4'hF;
        end else begin
            in_meta <= bus.nibble_bus;
            in_sync <= in_meta;
        end
    end

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    // Response window is bounded so a silent device (bad size or no
    // select match) never hangs the host.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state                     <= NBRT_IDLE;
            cnt                       <= 5'h00;
            addr                      <= '0;
            sel                       <= 4'h0;
            size                      <= 4'h0;
            busy                      <= 1'b0;
            done                      <= 1'b0;
            rdata                     <= 8'h00;
            got_ready                 <= 1'b0;
            bus.frame_control_input_n <= 1'b1;
            bus.host_out              <= NBRT_TURN;
            bus.host_oe               <= 4'h0;
        end else begin
            done <= 1'b0;
            case (state)
                NBRT_IDLE: if (req) begin
                    addr                      <= req_address;
                    sel                       <= req_select;
                    size                      <= req_size;
                    busy                      <= 1'b1;
                    got_ready                 <= 1'b0;
                    bus.frame_control_input_n <= 1'b0;
                    bus.host_out              <= NBRT_START_READ;
                    bus.host_oe               <= 4'hF;
                    state                     <= NBRT_SEL;
                end
                NBRT_SEL: begin
                    bus.frame_control_input_n <= 1'b1;
                    bus.host_out              <= sel;
                    cnt                       <= 5'h00;
                    state                     <= NBRT_ADDR;
                end
                NBRT_ADDR: begin
                    bus.host_out <= addr[NBRT_ADDR_W-1 -: 4];
                    addr         <= {addr[NBRT_ADDR_W-5:0], 4'h0};
                    cnt          <= cnt + 5'h01;
                    if (cnt == 5'(NBRT_ADDR_NIBS - 1)) begin
                        state <= NBRT_SIZE;
                    end
                end
                NBRT_SIZE: begin
                    bus.host_out <= size;
                    state        <= NBRT_TURNAROUND_FIRST;
                end
                NBRT_TURNAROUND_FIRST: begin
                    bus.host_out <= NBRT_TURN;
                    cnt          <= 5'h00;
                    state        <= NBRT_SYNC;
                end
                NBRT_SYNC: begin
                    bus.host_oe <= 4'h0;
                    cnt         <= cnt + 5'h01;
                    if (got_ready) begin
                        rdata[3:0] <= in_sync;
                        state      <= NBRT_DATA;
                    end else if (cnt > 5'h02 && in_sync == NBRT_READY_SYNC) begin
                        got_ready <= 1'b1;
                    end else if (cnt == 5'h1F) begin
                        busy  <= 1'b0;
                        done  <= 1'b1;
                        state <= NBRT_IDLE;
                    end
                end
                NBRT_DATA: begin
                    rdata[7:4] <= in_sync;
                    state      <= NBRT_HTAR;
                end
                NBRT_HTAR: begin
                    busy  <= 1'b0;
                    done  <= 1'b1;
                    state <= NBRT_IDLE;
                end
                default: state <= NBRT_IDLE;
            endcase
        end
    end

endmodule

// ### hdl/nbrt_if.sv
// Interface carrying the four-line nibble bus and the frame control input
`timescale 1ns/1ps
interface nbrt_if;
    logic [3:0] host_out;
    logic [3:0] host_oe;
    logic [3:0] dev_out;
    logic [3:0] dev_oe;
    logic       frame_control_input_n;
    logic [3:0] nibble_bus;

    // Wired bus with pull-ups: undriven lines read high
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            nibble_bus[i] = host_oe[i] ? host_out[i] : (dev_oe[i] ? dev_out[i] : 1'b1);
        end
    end

    modport device (input nibble_bus, input frame_control_input_n,
                    output dev_out, output dev_oe);
    modport host   (input nibble_bus, output frame_control_input_n,
                    output host_out, output host_oe);
endinterface

// ### hdl/nbrt_pkg.sv
// Constants and types shared by both ends of the nibble bus read link
package nbrt_pkg;

    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    localparam logic [3:0] NBRT_START_READ = 4'hD;
    localparam logic [3:0] NBRT_SIZE_ONE   = 4'h0;
    localparam logic [3:0] NBRT_TURN       = 4'hF;
    localparam logic [3:0] NBRT_WAIT_SYNC  = 4'h5;
    localparam logic [3:0] NBRT_READY_SYNC = 4'h0;

    // ------------------------------------------------------------
    // Layout and timing
    // ------------------------------------------------------------
    localparam int         NBRT_ADDR_W      = 28;
    localparam int         NBRT_ADDR_NIBS   = 7;
    localparam int         NBRT_CORE_SEL    = 22;
    localparam int         NBRT_WAIT_CLOCKS = 2;
    localparam logic [2:0] NBRT_CNT_ONE     = 3'h1;
    localparam logic [2:0] NBRT_CNT_ZERO    = 3'h0;

    typedef enum logic [9:0] {
        NBRT_IDLE  = 10'h001,
        NBRT_SEL   = 10'h002,
        NBRT_ADDR  = 10'h004,
        NBRT_SIZE  = 10'h008,
        NBRT_TURNAROUND_FIRST  = 10'h010,
        NBRT_TURNAROUND_SECOND  = 10'h020,
        NBRT_SYNC  = 10'h040,
        NBRT_DATA  = 10'h080,
        NBRT_DTAR  = 10'h100,
        NBRT_HTAR  = 10'h200
    } nbrt_state_t;

endpackage

// ### tb/nbrt_checker.sv
// Concurrent checks on the nibble bus between the host and device ends
`timescale 1ns/1ps
module nbrt_checker
    import nbrt_pkg::*;
#(
    parameter logic [3:0] STRAP = 4'h0
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [3:0] host_out,
    input wire logic [3:0] host_oe,
    input wire logic [3:0] dev_out,
    input wire logic [3:0] dev_oe,
    input wire logic       frame_control_input_n,
    input wire logic [3:0] nibble_bus
);
    // ------------------------------------------------------------
    // Field position tracking
    // ------------------------------------------------------------
    logic [5:0] cnt;
    logic       sel_ok;
    logic       size_ok;

    // Saturates so that a long idle never wraps into a false field position
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= 6'h00;
        end else if (!frame_control_input_n) begin
            cnt <= 6'h01;
        end else if (cnt != 6'h00 && cnt != 6'h3F) begin
            cnt <= cnt + 6'h01;
        end
    end

    // Frame low clears synchronously; only rst is an asynchronous reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sel_ok <= 1'b0;
        end else if (!frame_control_input_n) begin
            sel_ok <= 1'b0;
        end else if (cnt == 6'h01) begin
            sel_ok <= (nibble_bus == STRAP);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            size_ok <= 1'b0;
        end else if (!frame_control_input_n) begin
            size_ok <= 1'b0;
        end else if (cnt == 6'h09) begin
            size_ok <= (nibble_bus == NBRT_SIZE_ONE);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_start_code_read: assert property (
        $fell(frame_control_input_n) |-> nibble_bus == NBRT_START_READ)
        else $error("start field is not the read code");
    a_respond_on_match: assert property (
        dev_oe != 4'h0 |-> sel_ok && size_ok)
        else $error("device drove without matching select and size");
    a_bad_size_silent: assert property (
        cnt == 6'h09 && nibble_bus != NBRT_SIZE_ONE |-> ##1 (dev_oe == 4'h0)[*8])
        else $error("device answered a bad size");
    a_host_turn_first: assert property (
        cnt == 6'h0A |-> host_oe == 4'hF && host_out == NBRT_TURN ##1 host_oe == 4'h0)
        else $error("host turnaround wrong");
    a_sync_then_turn: assert property (
        (dev_oe == 4'hF && dev_out == NBRT_TURN) ##1 dev_oe == 4'h0
        |-> $past(dev_out, 4) == NBRT_READY_SYNC
            && $past(dev_out, 5) == NBRT_WAIT_SYNC
            && $past(dev_out, 6) == NBRT_WAIT_SYNC)
        else $error("sync order before data wrong");
    a_abort_release: assert property (
        !frame_control_input_n |-> ##3 dev_oe == 4'h0)
        else $error("device kept driving after frame low");
    a_no_contention: assert property (
        !(host_oe != 4'h0 && dev_oe != 4'h0))
        else $error("both ends drive the bus");
    a_full_width: assert property (
        dev_oe == 4'h0 || dev_oe == 4'hF)
        else $error("device drives a partial nibble");

    c_read_done: cover property ((dev_oe == 4'hF) ##1 (dev_oe == 4'h0));
    c_bad_size: cover property (cnt == 6'h09 && nibble_bus != NBRT_SIZE_ONE);
    c_mismatch: cover property (cnt == 6'h01 && nibble_bus != STRAP);
endmodule

// ### tb/nbrt_tb_top.sv
// Testbench joining host and device ends, plus a hand-driven abort link
`timescale 1ns/1ps
module nbrt_tb_top;
    import nbrt_pkg::*;
    localparam logic [3:0]  STRAP = 4'h6;
    localparam logic [27:0] ADDRS [4] = '{28'hFFC0123, 28'hFB80004, 28'h0400001, 28'h0000002};
    localparam logic [7:0]  DATAS [4] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0};
    logic        mclk;
    logic        rst;
    logic        req;
    logic [3:0]  req_select;
    logic [3:0]  req_size;
    logic [27:0] req_address;
    logic [27:0] read_address;
    logic [7:0]  read_data;
    logic [7:0]  rdata;
    logic        core_select;
    logic        read_strobe;
    logic        busy;
    logic        done;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          strobes = 0;
    int          k;

    nbrt_if bus ();
    nbrt_if bus2 ();
    nbrt_host nbrt_host_i (.mclk(mclk), .rst(rst), .bus(bus), .req(req), .req_select(req_select),
        .req_size(req_size), .req_address(req_address), .busy(busy), .done(done), .rdata(rdata));
    nbrt_device nbrt_device_i (.mclk(mclk), .rst(rst), .bus(bus), .strap_identifier(STRAP),
        .read_data(read_data), .read_address(read_address), .core_select(core_select),
        .read_strobe(read_strobe));
    nbrt_device nbrt_device_abort_i (.mclk(mclk), .rst(rst), .bus(bus2), .strap_identifier(STRAP),
        .read_data(read_data), .read_address(), .core_select(), .read_strobe());
    nbrt_checker #(.STRAP(STRAP)) nbrt_checker_i (.mclk(mclk), .rst(rst),
        .host_out(bus.host_out), .host_oe(bus.host_oe), .dev_out(bus.dev_out),
        .dev_oe(bus.dev_oe), .frame_control_input_n(bus.frame_control_input_n),
        .nibble_bus(bus.nibble_bus));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (read_strobe === 1'b1) begin
            strobes++;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One host transfer; read_data is set early as the core must be valid by the sync phase
    task automatic do_read(input logic [3:0] sel, input logic [3:0] size, input logic [27:0] addr,
                           input logic [7:0] data);
        @(posedge mclk);
        #1;
        req_select = sel;
        req_size = size;
        req_address = addr;
        read_data = data;
        req = 1'b1;
        @(posedge mclk);
        #1;
        req = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 80) begin
            @(posedge mclk);
            #1;
            k++;
        end
        check(k < 80, 1'b1, "done pulse");
    endtask

    // Drives the second link in the host's place
    task automatic drv2(input logic fr, input logic [3:0] nib, input logic [3:0] oe);
        @(posedge mclk);
        #1;
        bus2.frame_control_input_n = fr;
        bus2.host_out = nib;
        bus2.host_oe = oe;
    endtask

    initial begin
        #300000;
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        req = 1'b0;
        req_select = 4'h0;
        req_size = 4'h0;
        req_address = 28'h0000000;
        read_data = 8'h00;
        bus2.frame_control_input_n = 1'b1;
        bus2.host_out = 4'hF;
        bus2.host_oe = 4'h0;
        repeat (2) @(posedge mclk);
        check(bus.dev_oe, 4'h0, "device lines in reset");
        check(bus.frame_control_input_n, 1'b1, "frame in reset");
        #1;
        rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            do_read(STRAP, NBRT_SIZE_ONE, ADDRS[i], DATAS[i]);
            check(rdata, DATAS[i], "read byte");
            check(read_address, ADDRS[i], "assembled address");
            check(core_select, ADDRS[i][NBRT_CORE_SEL], "core select");
            check(strobes, i + 1, "strobe count");
            check(busy, 1'b0, "host idle after read");
        end
        $display("test good reads finished");
        for (int s = 1; s < 16; s++) begin
            do_read(STRAP, s[3:0], ADDRS[0], DATAS[0]);
            check(strobes, 4, "strobe after bad size");
        end
        $display("test bad sizes finished");
        do_read(STRAP ^ 4'h9, NBRT_SIZE_ONE, ADDRS[1], DATAS[1]);
        check(strobes, 4, "strobe after select mismatch");
        $display("test select mismatch finished");
        // A non-read start, then the read start: only the last one counts
        drv2(1'b0, 4'h0, 4'hF);
        drv2(1'b0, NBRT_START_READ, 4'hF);
        drv2(1'b1, STRAP, 4'hF);
        for (int n = 6; n >= 0; n--) begin
            drv2(1'b1, ADDRS[0][n*4 +: 4], 4'hF);
        end
        drv2(1'b1, NBRT_SIZE_ONE, 4'hF);
        drv2(1'b1, NBRT_TURN, 4'hF);
        drv2(1'b1, NBRT_TURN, 4'h0);
        k = 0;
        while (bus2.dev_oe !== 4'hF && k < 12) begin
            @(posedge mclk);
            #1;
            k++;
        end
        check(bus2.dev_oe, 4'hF, "device took the lines");
        check(bus2.nibble_bus, NBRT_WAIT_SYNC, "first sync is wait");
        drv2(1'b0, 4'hF, 4'h0);
        repeat (3) @(posedge mclk);
        #1;
        check(bus2.dev_oe, 4'h0, "release on frame low");
        drv2(1'b1, 4'hF, 4'h0);
        repeat (20) @(posedge mclk);
        #1;
        check(bus2.dev_oe, 4'h0, "stays released after abort");
        $display("test abort finished");
        give_verdict();
    end
endmodule
